// >>> hw/timer_reload_pwm.sv
`include "timer_reload_pwm_defines.svh"
module timer_reload_pwm (
   input wire logic clk,
   input wire logic rst_n,
   input wire timer_reload_pwm_pkg::avmm_req_t avm_req,
   output logic [31:0] avm_readdata,
   output logic avm_waitrequest,
   input wire logic fcpu_tick,
   input wire logic fhosc_tick,
   input wire logic event_input_pin,
   input wire logic gpio_out_level,
   output timer_reload_pwm_pkg::pin_ctrl_t pin_ctrl,
   output logic overflow_irq
);
   import timer_reload_pwm_pkg::*;

   // ==========================================
   // Reset release
   logic rst_meta_reg;
   logic rst_sync_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n <= rst_meta_reg;
      end
   end

   // ==========================================
   // Bus slave: one wait cycle, then answer
   logic ack_reg;
   logic [7:0] idx;
   logic bus_wr;
   logic wr_lane0;
   logic wr_mode;
   logic wr_count;
   logic wr_reload;
   logic wr_duty;
   logic wr_status;

   assign idx = avm_req.address[9:2];
   assign avm_waitrequest = (avm_req.read | avm_req.write) & ~ack_reg;
   assign bus_wr = avm_req.write & ack_reg;
   assign wr_lane0 = bus_wr & avm_req.byteenable[0];
   assign wr_mode = wr_lane0 & (idx == `IDX_MODE_CONTROL);
   assign wr_count = wr_lane0 & (idx == `IDX_COUNT_VALUE);
   assign wr_reload = wr_lane0 & (idx == `IDX_RELOAD_VALUE);
   assign wr_duty = wr_lane0 & (idx == `IDX_DUTY_COMPARE);
   assign wr_status = wr_lane0 & (idx == `IDX_STATUS_CTRL);

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avm_req.read | avm_req.write) & ~ack_reg;
      end
   end

   // ==========================================
   // Registers
   mode_control_t mode_reg;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic [7:0] reload_pending_reg;
   logic [7:0] reload_active_reg;
   logic [7:0] duty_reg;
   logic flag_reg;
   logic ien_reg;
   logic run_prev_reg;
   logic start;
   logic tick;
   logic ovf;
   logic cycle_start;

   assign start = mode_reg.timer_run_bit & ~run_prev_reg;
   assign ovf = tick & (count_reg == `COUNT_FULL);
   assign cycle_start = start | ovf;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         run_prev_reg <= 1'b0;
      end else begin
         run_prev_reg <= mode_reg.timer_run_bit;
      end
   end

   // Software write wins over the one-pulse auto-clear so a re-arm is never lost
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mode_reg <= mode_control_t'(`RST_BYTE);
      end else if (wr_mode) begin
         mode_reg <= mode_control_t'(avm_req.writedata[7:0]);
      end else if (ovf & mode_reg.one_pulse_select & mode_reg.pwm_output_enable) begin
         mode_reg.pwm_output_enable <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         duty_reg <= `RST_BYTE;
      end else if (wr_duty) begin
         duty_reg <= avm_req.writedata[7:0];
      end
   end

   // Holding buffer; active copy only changes at a cycle boundary
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reload_pending_reg <= `RST_BYTE;
         reload_active_reg <= `RST_BYTE;
      end else begin
         if (wr_reload) begin
            reload_pending_reg <= avm_req.writedata[7:0];
         end
         if (cycle_start) begin
            reload_active_reg <= reload_pending_reg;
         end
      end
   end

   // ==========================================
   // Clock selection and prescaler
   logic [6:0] pre_reg;
   logic [6:0] pre_mask;
   logic src_tick;
   logic div_tick;

   assign src_tick = mode_reg.internal_source_select ? fhosc_tick : fcpu_tick;
   assign pre_mask = `PRESCALE_MASK_ALL >> mode_reg.prescale_rate;
   assign div_tick = src_tick & ((pre_reg & pre_mask) == pre_mask);

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pre_reg <= 7'h00;
      end else if (start) begin
         pre_reg <= 7'h00;
      end else if (src_tick) begin
         pre_reg <= pre_reg + 7'h01;
      end
   end

   // ==========================================
   // Event input: synchroniser, then falling-edge detect
   logic ev_meta_reg;
   logic ev_sync_reg;
   logic ev_prev_reg;
   logic ev_fall;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ev_meta_reg <= 1'b1;
         ev_sync_reg <= 1'b1;
         ev_prev_reg <= 1'b1;
      end else begin
         ev_meta_reg <= event_input_pin;
         ev_sync_reg <= ev_meta_reg;
         ev_prev_reg <= ev_sync_reg;
      end
   end

   assign ev_fall = ev_prev_reg & ~ev_sync_reg;

   // Start cycle never counts, so the loaded value is seen for a full count
   assign tick = mode_reg.timer_run_bit & ~start &
                 (mode_reg.external_clock_select ? ev_fall : div_tick);

   // ==========================================
   // Counter
   always_comb begin
      count_next = count_reg;
      if (wr_count) begin
         count_next = avm_req.writedata[7:0];
      end else if (cycle_start) begin
         count_next = reload_pending_reg;
      end else if (tick) begin
         count_next = count_reg + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count_reg <= `RST_BYTE;
      end else begin
         count_reg <= count_next;
      end
   end

   // ==========================================
   // Overflow flag and interrupt; a set in the clear cycle wins
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         flag_reg <= 1'b0;
         ien_reg <= 1'b0;
      end else begin
         if (ovf) begin
            flag_reg <= 1'b1;
         end else if (wr_status & avm_req.writedata[`STAT_FLAG_BIT]) begin
            flag_reg <= 1'b0;
         end
         if (wr_status) begin
            ien_reg <= avm_req.writedata[`STAT_IEN_BIT];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         overflow_irq <= 1'b0;
      end else begin
         overflow_irq <= (flag_reg | ovf) & ien_reg;
      end
   end

   // ==========================================
   // PWM waveform
   logic pwm_level_reg;
   logic pwm_sel;

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pwm_level_reg <= 1'b0;
      end else if (cycle_start) begin
         pwm_level_reg <= (duty_reg > reload_pending_reg);
      end else if (count_next == duty_reg) begin
         pwm_level_reg <= 1'b0;
      end
   end

   assign pwm_sel = mode_reg.timer_run_bit & mode_reg.pwm_output_enable;

   // ==========================================
   // Pin control, all registered
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_ctrl <= '0;
      end else begin
         pin_ctrl.pwm_output_pin <= pwm_sel ? pwm_level_reg : gpio_out_level;
         pin_ctrl.pwm_pin_owned <= pwm_sel;
         pin_ctrl.event_wake_disable <= mode_reg.external_clock_select;
         pin_ctrl.event_pin_int_flag_hold <= mode_reg.external_clock_select;
      end
   end

   // ==========================================
   // Read path, latched in the wait cycle
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      unique case (idx)
         `IDX_MODE_CONTROL: rd_byte = mode_reg;
         `IDX_COUNT_VALUE: rd_byte = count_reg;
         `IDX_DUTY_COMPARE: rd_byte = duty_reg;
         `IDX_STATUS_CTRL: rd_byte = {6'h00, ien_reg, flag_reg};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         avm_readdata <= 32'h00000000;
      end else if (avm_req.read & ~ack_reg) begin
         avm_readdata <= {24'h000000, rd_byte};
      end
   end

   // ==========================================
   // Checks
   property p_autoload;
      @(posedge clk) disable iff (!rst_sync_n)
      (ovf && !wr_count) |=> (count_reg == $past(reload_pending_reg));
   endproperty
   a_autoload: assert property (p_autoload) else $error("no reload at overflow");

   property p_hold_buffer;
      @(posedge clk) disable iff (!rst_sync_n)
      (wr_reload && !cycle_start) |=> (reload_active_reg == $past(reload_active_reg));
   endproperty
   a_hold_buffer: assert property (p_hold_buffer) else $error("active reload moved early");

   property p_start_load;
      @(posedge clk) disable iff (!rst_sync_n)
      (start && !wr_count) |=> (count_reg == $past(reload_pending_reg));
   endproperty
   a_start_load: assert property (p_start_load) else $error("no load on enable");

   property p_pin_pwm;
      @(posedge clk) disable iff (!rst_sync_n)
      pwm_sel |=> (pin_ctrl.pwm_output_pin == $past(pwm_level_reg)) && pin_ctrl.pwm_pin_owned;
   endproperty
   a_pin_pwm: assert property (p_pin_pwm) else $error("pin not driven by pwm");

   property p_cycle_high;
      @(posedge clk) disable iff (!rst_sync_n)
      (ovf && duty_reg > reload_pending_reg) |=> pwm_level_reg;
   endproperty
   a_cycle_high: assert property (p_cycle_high) else $error("pwm not high at cycle start");

   property p_duty_low;
      @(posedge clk) disable iff (!rst_sync_n)
      (cycle_start && !(duty_reg > reload_pending_reg)) |=> !pwm_level_reg;
   endproperty
   a_duty_low: assert property (p_duty_low) else $error("pwm high with small duty");

   property p_compare_low;
      @(posedge clk) disable iff (!rst_sync_n)
      (tick && !cycle_start && count_next == duty_reg) |=> !pwm_level_reg;
   endproperty
   a_compare_low: assert property (p_compare_low) else $error("pwm high after compare");

   property p_flag_set;
      @(posedge clk) disable iff (!rst_sync_n)
      ovf |=> flag_reg ##1 (overflow_irq == $past(ien_reg));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag or irq missing");

   property p_flag_sticky;
      @(posedge clk) disable iff (!rst_sync_n)
      (flag_reg && !wr_status) |=> flag_reg;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by itself");

   property p_gpio_back;
      @(posedge clk) disable iff (!rst_sync_n)
      !pwm_sel |=> (pin_ctrl.pwm_output_pin == $past(gpio_out_level));
   endproperty
   a_gpio_back: assert property (p_gpio_back) else $error("pin not returned to gpio");

   property p_event_count;
      @(posedge clk) disable iff (!rst_sync_n)
      (mode_reg.timer_run_bit && mode_reg.external_clock_select && !start && !wr_count
       && $fell(ev_sync_reg)) |=> (count_reg != $past(count_reg));
   endproperty
   a_event_count: assert property (p_event_count) else $error("event edge not counted");

   property p_event_block;
      @(posedge clk) disable iff (!rst_sync_n)
      mode_reg.external_clock_select ##1 mode_reg.external_clock_select |->
         pin_ctrl.event_pin_int_flag_hold && pin_ctrl.event_wake_disable;
   endproperty
   a_event_block: assert property (p_event_block) else $error("event pin not blocked");

   property p_one_pulse;
      @(posedge clk) disable iff (!rst_sync_n)
      (ovf && mode_reg.one_pulse_select && mode_reg.pwm_output_enable && !wr_mode)
         |=> !mode_reg.pwm_output_enable ##1 !pin_ctrl.pwm_pin_owned;
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("one pulse not ended");

   property p_stopped;
      @(posedge clk) disable iff (!rst_sync_n)
      (!mode_reg.timer_run_bit && !wr_count) |=> (count_reg == $past(count_reg));
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved while stopped");
endmodule

// >>> shared/timer_reload_pwm_defines.svh
`ifndef TIMER_RELOAD_PWM_DEFINES_SVH
`define TIMER_RELOAD_PWM_DEFINES_SVH
// ==========================================
// Register indices (byte address = 4 * index)
`define IDX_MODE_CONTROL 8'hb4
`define IDX_COUNT_VALUE 8'hb5
`define IDX_RELOAD_VALUE 8'hb6
`define IDX_DUTY_COMPARE 8'hb7
`define IDX_STATUS_CTRL 8'hbc
// ==========================================
// Bus geometry
`define BUS_ADDR_W 10
`define BUS_DATA_W 32
// ==========================================
// Mode control field positions
`define MODE_RUN_BIT 7
`define MODE_RATE_HI 6
`define MODE_RATE_LO 4
`define MODE_EXT_BIT 3
`define MODE_SRC_BIT 2
`define MODE_PULSE_BIT 1
`define MODE_PWM_BIT 0
// ==========================================
// Status/control field positions
`define STAT_FLAG_BIT 0
`define STAT_IEN_BIT 1
// ==========================================
// Reset values and counter constants
`define RST_BYTE 8'h00
`define COUNT_FULL 8'hff
`define PRESCALE_MASK_ALL 7'h7f
`endif

// >>> shared/timer_reload_pwm_pkg.sv
package timer_reload_pwm_pkg;
   // ==========================================
   // Mode control layout, bit 7 down to bit 0
   typedef struct packed {
      logic timer_run_bit;
      logic [2:0] prescale_rate;
      logic external_clock_select;
      logic internal_source_select;
      logic one_pulse_select;
      logic pwm_output_enable;
   } mode_control_t;

   // ==========================================
   // Avalon-MM request from the master
   typedef struct packed {
      logic read;
      logic write;
      logic [9:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avmm_req_t;

   // ==========================================
   // Pin-facing outputs
   typedef struct packed {
      logic pwm_output_pin;
      logic pwm_pin_owned;
      logic event_wake_disable;
      logic event_pin_int_flag_hold;
   } pin_ctrl_t;
endpackage

// >>> tb/timer_reload_pwm_test.sv
`include "timer_reload_pwm_defines.svh"
module timer_reload_pwm_test;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_reload_pwm_pkg::*;
   // ==========================================
   // Signals and model state
   logic clk;
   logic rst_n;
   avmm_req_t avm_req;
   logic [31:0] avm_readdata;
   logic avm_waitrequest;
   logic fcpu_tick;
   logic fhosc_tick;
   logic event_input_pin;
   logic gpio_out_level;
   pin_ctrl_t pin_ctrl;
   logic overflow_irq;
   int failures;
   int n_checks;
   logic [31:0] seed;
   logic [31:0] rdv;
   logic [7:0] base;
   logic g;
   int c;
   int r_act;
   int r_hold;
   int duty;

   timer_reload_pwm dut_u (
      .clk(clk),
      .rst_n(rst_n),
      .avm_req(avm_req),
      .avm_readdata(avm_readdata),
      .avm_waitrequest(avm_waitrequest),
      .fcpu_tick(fcpu_tick),
      .fhosc_tick(fhosc_tick),
      .event_input_pin(event_input_pin),
      .gpio_out_level(gpio_out_level),
      .pin_ctrl(pin_ctrl),
      .overflow_irq(overflow_irq)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========================================
   // Helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task final_report;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Request held until waitrequest is seen low; one idle edge after release
   task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rd_out);
      avm_req.read <= ~wr_en;
      avm_req.write <= wr_en;
      avm_req.address <= {idx, 2'b00};
      avm_req.writedata <= wd;
      avm_req.byteenable <= be;
      // Only the watchdog ends a wait that never completes
      do begin
         @(posedge clk);
      end while (avm_waitrequest !== 1'b0);
      rd_out = avm_readdata;
      avm_req.read <= 1'b0;
      avm_req.write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] t;
      bus(1'b1, idx, {24'h0, d}, 4'hf, t);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] t;
      bus(1'b0, idx, 32'h0, 4'hf, t);
      chk(t, exp);
   endtask

   // Ends on an edge so the next drive is a non-blocking change right after it
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask

   // One source pulse per call step; rate 111 makes each pulse one count
   task automatic tick(input logic hosc, input int n);
      repeat (n) begin
         if (hosc)
            fhosc_tick <= 1'b1;
         else
            fcpu_tick <= 1'b1;
         @(posedge clk);
         fhosc_tick <= 1'b0;
         fcpu_tick <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic setup(input logic [7:0] v, input logic [7:0] d, input logic [7:0] mode);
      wr(`IDX_MODE_CONTROL, 8'h00);
      wr(`IDX_COUNT_VALUE, v);
      wr(`IDX_RELOAD_VALUE, v);
      wr(`IDX_DUTY_COMPARE, d);
      wr(`IDX_STATUS_CTRL, 8'h03);
      wr(`IDX_MODE_CONTROL, mode);
      c = v;
      r_act = v;
      r_hold = v;
      duty = d;
   endtask

   // Reference PWM: high while count is below duty, only if duty beats reload
   task automatic pwm_steps(input int n);
      repeat (n) begin
         tick(1'b0, 1);
         if (c == 255) begin
            c = r_hold;
            r_act = r_hold;
         end else begin
            c++;
         end
         settle();
         chk(pin_ctrl.pwm_output_pin, {31'h0, duty > r_act && c < duty});
      end
   endtask

   // ==========================================
   // Main sequence
   initial begin
      avm_req = '0;
      fcpu_tick = 1'b0;
      fhosc_tick = 1'b0;
      event_input_pin = 1'b1;
      gpio_out_level = 1'b0;
      rst_n = 1'b0;
      seed = 32'hd417;
      failures = 0;
      n_checks = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(`IDX_MODE_CONTROL, 32'h0);
      rdc(`IDX_COUNT_VALUE, 32'h0);
      rdc(`IDX_RELOAD_VALUE, 32'h0);
      rdc(`IDX_DUTY_COMPARE, 32'h0);
      rdc(`IDX_STATUS_CTRL, 32'h0);
      rdc(8'hc0, 32'h0);
      chk(pin_ctrl.pwm_pin_owned, 32'h0);
      rdv = xs();
      wr(`IDX_DUTY_COMPARE, rdv[7:0]);
      rdc(`IDX_DUTY_COMPARE, {24'h0, rdv[7:0]});
      base = rdv[7:0];
      bus(1'b1, `IDX_DUTY_COMPARE, ~rdv, 4'he, rdv);
      rdc(`IDX_DUTY_COMPARE, {24'h0, base});
      wr(`IDX_RELOAD_VALUE, 8'h5a);
      rdc(`IDX_RELOAD_VALUE, 32'h0);
      // Stopped timer ignores ticks
      setup(8'h40, 8'h00, 8'h70);
      tick(1'b0, 5);
      rdc(`IDX_COUNT_VALUE, 32'h40);
      // Every rate: k full divider periods give exactly k counts, whatever the phase
      setup(8'h00, 8'h00, 8'hf0);
      for (int r = 0; r < 8; r++) begin
         wr(`IDX_MODE_CONTROL, {1'b1, r[2:0], 4'h0});
         bus(1'b0, `IDX_COUNT_VALUE, 32'h0, 4'hf, rdv);
         base = rdv[7:0];
         tick(1'b0, 2 << (7 - r));
         rdc(`IDX_COUNT_VALUE, {24'h0, 8'(base + 8'h02)});
      end
      wr(`IDX_MODE_CONTROL, 8'hf4);
      bus(1'b0, `IDX_COUNT_VALUE, 32'h0, 4'hf, rdv);
      base = rdv[7:0];
      tick(1'b0, 4);
      rdc(`IDX_COUNT_VALUE, {24'h0, base});
      tick(1'b1, 3);
      rdc(`IDX_COUNT_VALUE, {24'h0, 8'(base + 8'h03)});
      // Overflow reload through the holding buffer
      setup(8'hfe, 8'h00, 8'hf0);
      wr(`IDX_RELOAD_VALUE, 8'h10);
      tick(1'b0, 1);
      rdc(`IDX_COUNT_VALUE, 32'hff);
      rdc(`IDX_STATUS_CTRL, 32'h2);
      tick(1'b0, 1);
      rdc(`IDX_COUNT_VALUE, 32'h10);
      rdc(`IDX_STATUS_CTRL, 32'h3);
      chk(overflow_irq, 32'h1);
      tick(1'b0, 4);
      rdc(`IDX_STATUS_CTRL, 32'h3);
      wr(`IDX_STATUS_CTRL, 8'h03);
      rdc(`IDX_STATUS_CTRL, 32'h2);
      chk(overflow_irq, 32'h0);
      // PWM, with a period change in mid-cycle
      setup(8'h80, 8'ha0, 8'hf1);
      settle();
      chk(pin_ctrl.pwm_pin_owned, 32'h1);
      chk(pin_ctrl.pwm_output_pin, 32'h1);
      pwm_steps(100);
      wr(`IDX_RELOAD_VALUE, 8'hc0);
      r_hold = 8'hc0;
      pwm_steps(100);
      rdc(`IDX_STATUS_CTRL, 32'h3);
      // Pin back to GPIO while counting goes on
      rdv = xs();
      g = rdv[0];
      gpio_out_level <= g;
      wr(`IDX_MODE_CONTROL, 8'hf0);
      settle();
      chk(pin_ctrl.pwm_pin_owned, 32'h0);
      chk(pin_ctrl.pwm_output_pin, {31'h0, g});
      bus(1'b0, `IDX_COUNT_VALUE, 32'h0, 4'hf, rdv);
      base = rdv[7:0];
      tick(1'b0, 2);
      rdc(`IDX_COUNT_VALUE, {24'h0, 8'(base + 8'h02)});
      // Single pulse, then re-arm
      setup(8'hfc, 8'hfe, 8'hf3);
      pwm_steps(3);
      tick(1'b0, 1);
      rdc(`IDX_MODE_CONTROL, 32'hf2);
      rdc(`IDX_STATUS_CTRL, 32'h3);
      chk(pin_ctrl.pwm_pin_owned, 32'h0);
      chk(pin_ctrl.pwm_output_pin, {31'h0, g});
      wr(`IDX_MODE_CONTROL, 8'hf3);
      settle();
      chk(pin_ctrl.pwm_pin_owned, 32'h1);
      // Event counting; internal ticks run meanwhile and must not count
      setup(8'hfd, 8'h00, 8'hf8);
      fcpu_tick <= 1'b1;
      settle();
      chk(pin_ctrl.event_wake_disable, 32'h1);
      chk(pin_ctrl.event_pin_int_flag_hold, 32'h1);
      for (int i = 1; i <= 3; i++) begin
         event_input_pin <= 1'b0;
         repeat (8) @(posedge clk);
         event_input_pin <= 1'b1;
         repeat (8) @(posedge clk);
         rdc(`IDX_COUNT_VALUE, (i == 3) ? 32'hfd : 32'(8'hfd + i));
      end
      rdc(`IDX_STATUS_CTRL, 32'h3);
      fcpu_tick <= 1'b0;
      wr(`IDX_MODE_CONTROL, 8'h00);
      settle();
      chk(pin_ctrl.event_wake_disable, 32'h0);
      chk(pin_ctrl.event_pin_int_flag_hold, 32'h0);
      final_report();
   end

   // ==========================================
   // Watchdog: the sequence needs well under 10k cycles
   initial begin
      #100us;
      failures++;
      final_report();
   end
endmodule
